// [include/ext_event_cfg.svh]
// constants for the outside-event interrupt status block
// assumes a 32-bit AHB-Lite bus with word registers
//
// Function
// RULE1: outside-event register at index 24h, read/write, resets to zero.
// RULE2: software writes zero to reserved bits 31:24.
// RULE3: eight outside event inputs, numbered 0 to 7, are interrupt sources.
// RULE4: bit 23 is read-to-clear status for input 7.
// RULE5: bit 22 is read-to-clear status for input 6.
// RULE6: bits 21 down to 16 are read-to-clear status for inputs 5 down to 0.
// RULE7: each status flag clears on read; 1 means that input interrupted.
// RULE8: reading bits 23:16 clears per-input flags and the summary flag.
// RULE9: bits 15:8 show the same status without clearing anything.
// RULE10: summary flag sits at bit 10 of the status register at index 02h.
// RULE11: bits 7:0 enable each input; only enabled inputs interrupt.
// RULE12: each command register write always raises the interrupt.
// RULE13: interrupt stays high while any enabled status flag is set.
`ifndef EXT_EVENT_CFG_SVH
`define EXT_EVENT_CFG_SVH

// ------------------------------------------------------------
// register indices, byte address is four times the index
// ------------------------------------------------------------
`define EXT_REG_IDX     10'h024
`define TOP_REG_IDX     10'h002
`define IRQ_STAT_IDX    10'h028
`define IRQ_CLR_IDX     10'h029
`define IRQ_EN_IDX      10'h02A

// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define EXT_EN_LSB      0
`define EXT_VIEW_LSB    8
`define EXT_STAT_LSB    16
`define EXT_RSVD_LSB    24
`define TOP_CMD_BIT     0
`define TOP_EXT_BIT     10
`define STAT_LANE       2
`define CMD_LANE        0
`define EN_LANE         0
`define IRQ_EXT_BIT     0
`define IRQ_CMD_BIT     1
`define EN_RESET        8'h00
`define STAT_RESET      8'h00
`define IRQ_RESET       2'h0
`define WORD_ZERO       32'h0000_0000
`define RESP_OKAY       1'b0

`endif

// [include/ext_event_pkg.sv]
// types shared by the outside-event block and its bus port
// assumes ext_event_cfg.svh supplies the numeric constants
package ext_event_pkg;
	typedef logic [7:0]  event_vec_t;
	typedef logic [31:0] word_t;
	typedef logic [9:0]  word_idx_t;
	typedef logic [3:0]  lanes_t;
	typedef logic [1:0]  irq_vec_t;
	typedef enum logic {PH_IDLE, PH_WRITE} phase_t;
endpackage

// [rtl/ahb_word_port.sv]
// AHB-Lite slave front end: decodes transfers into word requests
// assumes one slave on the bus; never inserts wait states
`timescale 1ns/10ps
`include "ext_event_cfg.svh"
module ahb_word_port (
	input  wire logic                    hclk,      // bus clock
	input  wire logic                    hresetn,   // async reset, low
	input  wire logic                    hsel,      // slave select
	input  wire ext_event_pkg::word_t    haddr,     // byte address
	input  wire logic [1:0]              htrans,    // transfer type
	input  wire logic                    hwrite,    // write flag
	input  wire logic [2:0]              hsize,     // transfer size
	input  wire logic                    hready,    // bus ready
	output logic                         hreadyout, // slave ready
	output logic                         hresp,     // response
	output logic                         rd_req,    // read accepted
	output ext_event_pkg::word_idx_t     rd_word,   // read word index
	output ext_event_pkg::lanes_t        rd_lanes,  // read byte lanes
	output logic                         wr_req,    // write data phase
	output ext_event_pkg::word_idx_t     wr_word,   // write word index
	output ext_event_pkg::lanes_t        wr_lanes   // write byte lanes
);
	import ext_event_pkg::*;

	phase_t    phase_q;
	word_idx_t wr_word_q;
	lanes_t    wr_lanes_q;
	lanes_t    lanes;
	logic      take;

	// ------------------------------------------------------------
	// address phase
	// ------------------------------------------------------------
	always_comb begin
		case (hsize)
			3'h0:    lanes = lanes_t'(4'h1 << haddr[1:0]);
			3'h1:    lanes = haddr[1] ? 4'hC : 4'h3;
			default: lanes = 4'hF;
		endcase
	end

	assign take      = hsel && hready && htrans[1];
	assign rd_req    = take && !hwrite;
	assign rd_word   = haddr[11:2];
	assign rd_lanes  = lanes;
	assign hreadyout = 1'b1;
	assign hresp     = `RESP_OKAY;

	// ------------------------------------------------------------
	// data phase of writes
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_q <= PH_IDLE;
		end else begin
			case (phase_q)
				PH_IDLE,
				PH_WRITE: phase_q <= (take && hwrite) ? PH_WRITE : PH_IDLE;
				default:  phase_q <= PH_IDLE;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_word_q  <= '0;
			wr_lanes_q <= '0;
		end else if (take && hwrite) begin
			wr_word_q  <= haddr[11:2];
			wr_lanes_q <= lanes;
		end
	end

	assign wr_req   = (phase_q == PH_WRITE);
	assign wr_word  = wr_word_q;
	assign wr_lanes = wr_lanes_q;
endmodule

// [rtl/ext_event_smi.sv]
// outside-event interrupt status register with AHB-Lite access
// assumes event inputs and command pulse are synchronous to hclk
`timescale 1ns/10ps
`include "ext_event_cfg.svh"
module ext_event_smi #(
	parameter int N_EVENTS = 8 // number of outside event inputs
) (
	input  wire logic                    hclk,                // clock
	input  wire logic                    hresetn,             // reset, low
	input  wire logic                    hsel,                // slave select
	input  wire ext_event_pkg::word_t    haddr,               // address
	input  wire logic [1:0]              htrans,              // transfer
	input  wire logic                    hwrite,              // write flag
	input  wire logic [2:0]              hsize,               // size
	input  wire logic                    hready,              // bus ready
	input  wire ext_event_pkg::word_t    hwdata,              // write data
	output ext_event_pkg::word_t         hrdata,              // read data
	output logic                         hreadyout,           // ready out
	output logic                         hresp,               // response
	input  wire ext_event_pkg::event_vec_t outside_event_inputs, // events
	input  wire logic                    power_mgmt_command_write, // pulse
	output logic                         system_mgmt_interrupt, // level
	output logic                         event_irq            // level
);
	import ext_event_pkg::*;

	logic       rd_req;
	word_idx_t  rd_word;
	lanes_t     rd_lanes;
	logic       wr_req;
	word_idx_t  wr_word;
	lanes_t     wr_lanes;

	event_vec_t enable_q;
	event_vec_t status_q;
	event_vec_t prev_q;
	event_vec_t rise;
	event_vec_t rise_set;
	logic       top_q;
	logic       cmd_q;
	irq_vec_t   irq_stat_q;
	irq_vec_t   irq_en_q;
	irq_vec_t   irq_events;
	irq_vec_t   irq_clear;
	word_t      hrdata_q;
	word_t      rd_val;

	logic       ext_rd;
	logic       stat_rd_clr;
	logic       top_rd;
	logic       cmd_rd_clr;
	logic       ext_wr;

	// ------------------------------------------------------------
	// bus front end
	// ------------------------------------------------------------
	ahb_word_port u_port (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hready    (hready),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.rd_req    (rd_req),
		.rd_word   (rd_word),
		.rd_lanes  (rd_lanes),
		.wr_req    (wr_req),
		.wr_word   (wr_word),
		.wr_lanes  (wr_lanes)
	);

	assign ext_rd      = rd_req && (rd_word == `EXT_REG_IDX);
	// only a read that covers the status byte clears it, so a byte
	// read of the view lane leaves the interrupt pending
	assign stat_rd_clr = ext_rd && rd_lanes[`STAT_LANE]; // RULE8 RULE9
	assign top_rd      = rd_req && (rd_word == `TOP_REG_IDX);
	assign cmd_rd_clr  = top_rd && rd_lanes[`CMD_LANE];
	assign ext_wr      = wr_req && (wr_word == `EXT_REG_IDX);

	// ------------------------------------------------------------
	// event capture
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prev_q <= `STAT_RESET;
		end else begin
			prev_q <= outside_event_inputs;
		end
	end

	// an assertion is the low-to-high change of an input
	assign rise     = outside_event_inputs & ~prev_q; // RULE3
	assign rise_set = rise & enable_q;                // RULE11

	// ------------------------------------------------------------
	// enables, bits 7:0
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			enable_q <= `EN_RESET; // RULE1
		end else if (ext_wr && wr_lanes[`EN_LANE]) begin
			enable_q <= hwdata[`EXT_EN_LSB +: 8]; // RULE11
		end
	end

	// ------------------------------------------------------------
	// per-input status, bit 16+i; a new event beats the read clear
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < N_EVENTS; gi++) begin : g_stat
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					status_q[gi] <= 1'b0; // RULE1
				end else if (rise_set[gi]) begin
					status_q[gi] <= 1'b1; // RULE4 RULE5 RULE6
				end else if (stat_rd_clr) begin
					status_q[gi] <= 1'b0; // RULE7
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// summary flag and command flag
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			top_q <= 1'b0;
		end else if (|rise_set) begin
			top_q <= 1'b1; // RULE10
		end else if (stat_rd_clr) begin
			top_q <= 1'b0; // RULE8
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmd_q <= 1'b0;
		end else if (power_mgmt_command_write) begin
			cmd_q <= 1'b1; // RULE12
		end else if (cmd_rd_clr) begin
			cmd_q <= 1'b0;
		end
	end

	// the command source bypasses the enables on purpose
	assign system_mgmt_interrupt = (|(status_q & enable_q)) | cmd_q; // RULE13

	// ------------------------------------------------------------
	// interrupt status, clear and enable
	// ------------------------------------------------------------
	assign irq_events[`IRQ_EXT_BIT] = |rise_set;
	assign irq_events[`IRQ_CMD_BIT] = power_mgmt_command_write;
	assign irq_clear = (wr_req && (wr_word == `IRQ_CLR_IDX) && wr_lanes[0])
		? hwdata[1:0] : `IRQ_RESET;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_stat_q <= `IRQ_RESET;
		end else begin
			irq_stat_q <= irq_events | (irq_stat_q & ~irq_clear);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_en_q <= `IRQ_RESET;
		end else if (wr_req && (wr_word == `IRQ_EN_IDX) && wr_lanes[0]) begin
			irq_en_q <= hwdata[1:0];
		end
	end

	assign event_irq = |(irq_stat_q & irq_en_q);

	// ------------------------------------------------------------
	// read data, loaded at the address phase edge
	// ------------------------------------------------------------
	always_comb begin
		rd_val = `WORD_ZERO;
		case (rd_word)
			`EXT_REG_IDX: begin
				// reserved byte always reads zero whatever was written
				rd_val[`EXT_EN_LSB +: 8]   = enable_q;
				rd_val[`EXT_VIEW_LSB +: 8] = status_q; // RULE9
				rd_val[`EXT_STAT_LSB +: 8] = status_q; // RULE7
			end
			`TOP_REG_IDX: begin
				rd_val[`TOP_EXT_BIT] = top_q; // RULE10
				rd_val[`TOP_CMD_BIT] = cmd_q;
			end
			`IRQ_STAT_IDX: rd_val[1:0] = irq_stat_q;
			`IRQ_EN_IDX:   rd_val[1:0] = irq_en_q;
			default:       rd_val = `WORD_ZERO;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= `WORD_ZERO;
		end else if (rd_req) begin
			hrdata_q <= rd_val;
		end
	end

	assign hrdata = hrdata_q;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	sequence s_ext_rd;
		ext_rd;
	endsequence

	sequence s_clr_rd_quiet;
		stat_rd_clr && (rise_set == 8'h00);
	endsequence

	sequence s_en_wr;
		ext_wr && wr_lanes[`EN_LANE];
	endsequence

	property p_readback;
		s_ext_rd |=> hrdata == {8'h00, $past(status_q), $past(status_q),
			$past(enable_q)};
	endproperty
	a_readback: assert property (p_readback) // RULE1
		else $error("register readback wrong");

	// a write data phase, one idle edge, then the read address phase
	property p_rsvd_zero;
		s_en_wr ##2 s_ext_rd |=> hrdata[31:24] == 8'h00;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) // RULE2
		else $error("reserved bits not zero");

	property p_set;
		(rise_set != 8'h00) |=> ((status_q & $past(rise_set))
			== $past(rise_set)) && top_q;
	endproperty
	a_set: assert property (p_set) // RULE4
		else $error("enabled event not captured");

	// a masked rise must never turn a status bit on
	property p_no_set_disabled;
		((rise & ~enable_q) != 8'h00)
			|=> (status_q & ~$past(status_q) & ~$past(rise_set)) == 8'h00;
	endproperty
	a_no_set_disabled: assert property (p_no_set_disabled) // RULE11
		else $error("disabled event captured");

	property p_read_clear;
		s_clr_rd_quiet |=> (status_q == 8'h00) && !top_q;
	endproperty
	a_read_clear: assert property (p_read_clear) // RULE8
		else $error("status read did not clear");

	property p_view_keeps;
		(ext_rd && !rd_lanes[`STAT_LANE] && (status_q != 8'h00))
			|=> status_q != 8'h00;
	endproperty
	a_view_keeps: assert property (p_view_keeps) // RULE9
		else $error("view read cleared status");

	property p_top_tracks;
		top_q == (status_q != 8'h00);
	endproperty
	a_top_tracks: assert property (p_top_tracks) // RULE10
		else $error("summary flag mismatch");

	property p_enable_wr;
		s_en_wr |=> enable_q == $past(hwdata[7:0]);
	endproperty
	a_enable_wr: assert property (p_enable_wr) // RULE11
		else $error("enable write lost");

	property p_cmd_smi;
		power_mgmt_command_write |=> system_mgmt_interrupt [*2];
	endproperty
	a_cmd_smi: assert property (p_cmd_smi) // RULE12
		else $error("command write gave no interrupt");

	property p_smi_level;
		((status_q & enable_q) != 8'h00) |-> system_mgmt_interrupt;
	endproperty
	a_smi_level: assert property (p_smi_level) // RULE13
		else $error("interrupt dropped while pending");

	property p_smi_release;
		(!cmd_q && ((status_q & enable_q) == 8'h00))
			|-> !system_mgmt_interrupt;
	endproperty
	a_smi_release: assert property (p_smi_release) // RULE13
		else $error("interrupt high with nothing pending");
endmodule

// [verification/event_source.sv]
// partner model: the outside event sources and the command-write strobe
// assumes it shares hclk with the block and is steered by the bench
`timescale 1ns/10ps
module event_source (
	input  wire logic                 hclk,                     // clock
	output ext_event_pkg::event_vec_t outside_event_inputs,     // events
	output logic                      power_mgmt_command_write  // strobe
);
	import ext_event_pkg::*;

	initial begin
		outside_event_inputs = 8'h00;
		power_mgmt_command_write = 1'b0;
	end

	// ------------------------------------------------------------
	// stimulus tasks
	// ------------------------------------------------------------
	// a line may stay high for several cycles; only its rise may count
	task automatic fire(input event_vec_t m, input int hold);
		@(posedge hclk);
		outside_event_inputs <= m;
		repeat (hold) @(posedge hclk);
		outside_event_inputs <= 8'h00;
	endtask

	// one strobe for every command register write, with no enable
	task automatic command;
		@(posedge hclk);
		power_mgmt_command_write <= 1'b1;
		@(posedge hclk);
		power_mgmt_command_write <= 1'b0;
	endtask
endmodule

// [verification/tb_ext_event_smi.sv]
// self-checking bench for the outside-event interrupt status block
// assumes a single AHB-Lite slave whose hreadyout is the bus ready
`timescale 1ns/10ps
`include "ext_event_cfg.svh"
module tb_ext_event_smi;
	import ext_event_pkg::*;

	localparam word_t ALL    = 32'hFFFF_FFFF;
	localparam word_t A_EXT  = {20'h0, `EXT_REG_IDX, 2'b00};
	localparam word_t A_TOP  = {20'h0, `TOP_REG_IDX, 2'b00};
	localparam word_t A_STAT = {20'h0, `IRQ_STAT_IDX, 2'b00};
	localparam word_t A_CLR  = {20'h0, `IRQ_CLR_IDX, 2'b00};
	localparam word_t A_EN   = {20'h0, `IRQ_EN_IDX, 2'b00};

	logic       hclk    = 1'b0;
	logic       hresetn = 1'b0;
	logic       hsel    = 1'b0;
	word_t      haddr   = 32'h0000_0000;
	logic [1:0] htrans  = 2'h0;
	logic       hwrite  = 1'b0;
	logic [2:0] hsize   = 3'h2;
	word_t      hwdata  = 32'h0000_0000;
	word_t      hrdata;
	logic       hreadyout;
	logic       hresp;
	logic       system_mgmt_interrupt;
	logic       event_irq;
	logic       power_mgmt_command_write;
	event_vec_t outside_event_inputs;
	int         fail_count = 0;
	int         cmp_count  = 0;
	int         cycles     = 0;
	logic [15:0] rnd       = 16'h002F;
	word_t      regs [4]   = '{A_EXT, A_TOP, A_STAT, A_EN};

	always #2.5 hclk = ~hclk;

	ext_event_smi #(.N_EVENTS(8)) DUT (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
		.outside_event_inputs, .power_mgmt_command_write,
		.system_mgmt_interrupt, .event_irq
	);

	event_source src (
		.hclk, .outside_event_inputs, .power_mgmt_command_write
	);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic word_t exp_ext(input event_vec_t st, event_vec_t en);
		return {8'h00, st, st, en};
	endfunction

	task automatic chk(input word_t got, input word_t exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_b(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask

	// one single transfer; no fixed latency is assumed of the slave
	task automatic xfer(input word_t a, input logic w, input logic [2:0] sz,
			input word_t d, output word_t r);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= sz;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		r = hrdata;
		chk_b(hresp, 1'b0);
	endtask

	task automatic wr(input word_t a, input word_t d);
		word_t r;
		xfer(a, 1'b1, 3'h2, d, r);
	endtask

	task automatic rdc(input word_t a, input logic [2:0] sz, input word_t m,
			input word_t exp);
		word_t r;
		xfer(a, 1'b0, sz, 32'h0000_0000, r);
		chk(r & m, exp);
	endtask

	task automatic fire(input event_vec_t m, input int hold);
		src.fire(m, hold);
		@(negedge hclk);
	endtask

	task automatic conclude;
		if (fail_count == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// watchdog
	// ------------------------------------------------------------
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			conclude();
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		event_vec_t en;
		event_vec_t m;
		word_t      d;
		int         i;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		for (i = 0; i < 4; i++) rdc(regs[i], 3'h2, ALL, 32'h0);
		chk_b(system_mgmt_interrupt, 1'b0);
		rnd = lfsr(rnd);
		d = {8'h00, rnd, rnd[7:0]};
		wr(A_EXT, d);
		rdc(A_EXT, 3'h2, ALL, {24'h0, d[7:0]});
		// every input once, alternately enabled and masked
		for (i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			m = 8'h01 << i;
			en = i[0] ? rnd[7:0] & ~m : rnd[7:0] | m;
			wr(A_EXT, {24'h0, en});
			fire(m, int'(rnd[9:8]) + 1);
			chk_b(system_mgmt_interrupt, |(m & en));
			rdc(A_EXT + 1, 3'h0, 32'h0000_FF00,
				{16'h0, m & en, 8'h00});
			chk_b(system_mgmt_interrupt, |(m & en));
			rdc(A_TOP + 1, 3'h0, 32'h0000_0400,
				{21'h0, |(m & en), 10'h0});
			rdc(A_EXT, 3'h2, ALL,
				exp_ext(m & en, en));
			@(negedge hclk);
			chk_b(system_mgmt_interrupt, 1'b0);
			rdc(A_TOP, 3'h2, ALL, 32'h0);
		end
		rnd = lfsr(rnd);
		m = rnd[7:0] | 8'h81;
		wr(A_EXT, 32'h0000_00FF);
		fire(m, 1);
		rdc(A_EXT, 3'h2, ALL, exp_ext(m, 8'hFF));
		wr(A_EXT, 32'h0000_0000);
		fire(8'hFF, 2);
		chk_b(system_mgmt_interrupt, 1'b0);
		rdc(A_EXT, 3'h2, ALL, 32'h0);
		src.command();
		@(negedge hclk);
		chk_b(system_mgmt_interrupt, 1'b1);
		rdc(A_TOP, 3'h2, ALL, 32'h0000_0001);
		@(negedge hclk);
		chk_b(system_mgmt_interrupt, 1'b0);
		// interrupt status, enable and clear registers
		rdc(A_STAT, 3'h2, ALL, 32'h0000_0003);
		wr(A_CLR, 32'h0000_0003);
		rdc(A_STAT, 3'h2, ALL, 32'h0);
		wr(A_EN, 32'h0000_0003);
		rdc(A_EN, 3'h2, ALL, 32'h0000_0003);
		wr(A_EXT, 32'h0000_00FF);
		fire(8'h81, 1);
		chk_b(event_irq, 1'b1);
		rdc(A_STAT, 3'h2, ALL, 32'h0000_0001);
		wr(A_EN, 32'h0000_0002);
		@(negedge hclk);
		chk_b(event_irq, 1'b0);
		wr(A_CLR, 32'h0000_0001);
		rdc(A_STAT, 3'h2, ALL, 32'h0);
		// a half-word read of the low lanes must leave the status pending
		rdc(A_EXT, 3'h1, 32'h0000_FFFF, {16'h0, 8'h81, 8'hFF});
		rdc(A_EXT, 3'h2, ALL, exp_ext(8'h81, 8'hFF));
		// unmapped place: write ignored, read gives zero
		wr(32'h0000_0100, {rnd, rnd});
		rdc(32'h0000_0100, 3'h2, ALL, 32'h0);
		conclude();
	end
endmodule
